//--- src/sbx_strip_exchange.v
// Strip buffer exchange control between pixel buses and codec byte bus
// Functional notes
// - Expanding, frame busy rises on first codec sync, falls after window.
// - Window output marks window data; otherwise input passes to output.
// - Codec busy when pixel strip is free but codec strip still used.
// - No swap by line-sync rise: line dropped, or input shown when expanding.
// - Normal work resumes at next line-sync rise; narrow windows need slack.
// - Compressing, after last strip pixel check codec read-out, else busy.
// - Busy on line 8n: finish it, drop 8n+1, restart at 8n+2.
// - Expansion start raises busy until first strip loaded; input passes.
// - Expanding, after last strip pixel check next strip loaded, else busy.
// - Busy at line-sync rise while expanding: next line shows input.
// - Two strip buffers of 8 or 16 lines, or one line raster.
// - Strip memory accesses are 16-bit, alternating write and read slots.
// - A small sub-buffer keeps pixels flowing during codec-side access.
// - Codec bus moves one byte per clock whatever the format.
// - Codec pin directions follow the codec direction input.
// - Compression set but codec expanding and idle: assert stop.
// - Direction high: drive sync, end of scan, bytes; receive stop.
// - Compressing, frame busy rises at frame sync, falls at end of scan after last strip read-out.
// - Raster mode sync strobe enables each sample, not whole blocks.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "sbx_defs.vh"
module sbx_strip_exchange #(
  parameter AW = 13,
  parameter CW = 17,
  parameter PW = 8
) (
  input  wire          ref_clk,
  input  wire          rst_n,
  input  wire [7:0]    paddr,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire [PW-1:0] pixel_input_bus,
  input  wire          line_sync_in,
  input  wire          frame_sync_in,
  output reg  [PW-1:0] pixel_output_bus,
  output reg           window_out,
  output reg           frame_busy_flag,
  output wire          codec_side_busy_n,
  input  wire          codec_dir_in,
  input  wire          codec_sync_strobe_in_n,
  output reg           codec_sync_strobe_out_n,
  output wire          codec_sync_strobe_oe_n,
  input  wire          end_of_scan_in_n,
  output reg           end_of_scan_out_n,
  output wire          end_of_scan_oe_n,
  input  wire          stop_in_n,
  output reg           stop_out_n,
  output wire          stop_oe_n,
  input  wire [PW-1:0] codec_byte_bus_in,
  output reg  [PW-1:0] codec_byte_bus_out,
  output wire          codec_byte_bus_oe_n
);

  localparam HA  = AW - 1;
  localparam SWW = CW + 4;
  localparam SW  = 2 * PW + 6;
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_WAIT  = 2'b01;
  localparam [1:0] ST_FRAME = 2'b10;
  localparam [1:0] ST_DRAIN = 2'b11;
  localparam [CW-1:0]  ONE_C    = {{(CW-1){1'b0}}, 1'b1};
  localparam [SWW-1:0] ONE_S    = {{(SWW-1){1'b0}}, 1'b1};
  localparam [HA-1:0]  BLK_STEP = {{(HA-3){1'b0}}, `SBX_BLK_WORDS};

  // Two-flop synchronisers on every pin input
  wire [SW-1:0] pin_raw = {pixel_input_bus, codec_byte_bus_in, line_sync_in,
                           frame_sync_in, codec_dir_in, codec_sync_strobe_in_n,
                           end_of_scan_in_n, stop_in_n};
  reg  [SW-1:0] pin_meta;
  reg  [SW-1:0] pin_sync;
  genvar gi;
  generate
    for (gi = 0; gi < SW; gi = gi + 1)
    begin : g_sync
      always @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          pin_meta[gi] <= (gi < `SBX_LOW_PINS) ? 1'b1 : 1'b0;
          pin_sync[gi] <= (gi < `SBX_LOW_PINS) ? 1'b1 : 1'b0;
        end
        else
        begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  wire [PW-1:0] pix_in   = pin_sync[SW-1:PW+6];
  wire [PW-1:0] cbyte_in = pin_sync[PW+5:6];
  wire          hs       = pin_sync[5];
  wire          vs       = pin_sync[4];
  wire          cdir     = pin_sync[3];
  wire          csync_n  = pin_sync[2];
  wire          ceos_n   = pin_sync[1];
  wire          cstop_n  = pin_sync[0];

  reg           hs_d;
  reg           vs_d;
  reg           ceos_d_n;
  reg  [1:0]    state;
  reg           ctrl_go;
  reg           ctrl_cmp;
  reg           ctrl_raster;
  reg           ctrl_tall;
  reg  [CW-1:0] win_x0;
  reg  [CW-1:0] win_w;
  reg  [CW-1:0] win_y0;
  reg  [CW-1:0] win_h;
  reg           phase;
  reg           pix_buf;
  reg           pix_done;
  reg           codec_done;
  reg  [CW-1:0] px;
  reg  [CW-1:0] ly;
  reg  [CW-1:0] rows_done;
  reg           line_on;
  reg           line_skip;
  reg  [4:0]    pix_line;
  reg  [4:0]    pix_rows;
  reg           pix_final;
  reg           done_pend;
  reg  [HA-1:0] pix_addr;
  reg  [PW-1:0] wr_lo;
  reg  [15:0]   wr_word;
  reg           wr_pend;
  reg  [HA-1:0] f_addr;
  reg           rd_p_d;
  reg  [15:0]   qa;
  reg  [15:0]   qb;
  reg  [1:0]    qn;
  reg  [SWW-1:0] c_total;
  reg  [SWW-1:0] c_cnt;
  reg  [4:0]    c_rows;
  reg  [1:0]    cw;
  reg  [4:0]    cr;
  reg  [HA-1:0] row_base;
  reg  [HA-1:0] blk_base;
  reg           codec_last;
  reg           eos_seen;
  reg           rd_c_d;
  reg           first_d;
  reg           last_d;
  reg           hi_pend;
  reg           hi_first;
  reg           last_hold;
  reg  [PW-1:0] hi_hold;
  reg           eos_fire;
  reg  [PW-1:0] c_lo;
  reg           c_half;
  reg  [15:0]   c_wr_word;
  reg           c_wr_pend;
  wire [15:0]   mem_q;

  wire          hs_rise   = hs & ~hs_d;
  wire          vs_rise   = vs & ~vs_d;
  wire          ceos_fall = ceos_d_n & ~ceos_n;
  wire          active    = (state != ST_IDLE);
  wire [CW-2:0] half_w    = win_w[CW-1:1];
  wire [4:0]    strip_lines = ctrl_raster ? `SBX_LINES_RASTER :
                              ctrl_tall ? `SBX_LINES_TALL : `SBX_LINES_BLOCK;
  wire [SWW-1:0] strip_words = strip_lines * half_w;
  wire          busy      = active & pix_done & ~codec_done;
  wire          swap      = active & pix_done & codec_done;
  wire [CW:0]   x_end     = {1'b0, win_x0} + {1'b0, win_w};
  wire          in_win    = line_on & ({1'b0, px} >= {1'b0, win_x0}) &
                            ({1'b0, px} < x_end);
  wire [CW-1:0] rel_x     = px - win_x0;
  wire          rel_odd   = rel_x[0];
  wire          line_last = in_win & ({1'b0, px} == x_end - {1'b0, ONE_C});
  wire [CW-1:0] ly_next   = ly + ONE_C;
  wire          in_y      = (ly_next >= win_y0) & (rows_done < win_h);
  wire          row_last  = (rows_done == win_h - ONE_C);
  wire          strip_end = (pix_line == strip_lines - 5'h01) | row_last;
  wire          fe_exp    = ~ctrl_cmp & line_last & row_last;
  wire [HA-1:0] c_addr    = row_base + blk_base + {{(HA-2){1'b0}}, cw};
  wire          pix_wr_go = ~phase & wr_pend & ctrl_cmp;
  wire          cod_wr_go = ~phase & c_wr_pend & ~ctrl_cmp;
  wire          rd_c      = phase & ctrl_cmp & active & ~codec_done &
                            cdir & cstop_n;
  wire          pop       = in_win & ~ctrl_cmp & rel_odd;
  // A pop frees a slot; refill then or a pixel starves
  wire          rd_p      = phase & ~ctrl_cmp & active & ~pix_done &
                            ({{(SWW-HA){1'b0}}, f_addr} < strip_words) &
                            (((qn + {1'b0, rd_p_d}) < `SBX_QDEPTH) |
                             (pop & ~rd_p_d));
  wire          c_step    = rd_c | cod_wr_go;
  wire          c_end     = (c_cnt == c_total - ONE_S);
  wire          cbyte_ok  = active & ~ctrl_cmp & ~cdir & ~csync_n &
                            ~codec_done;
  wire          ctrl_wr   = psel & penable & pwrite &
                            (paddr == `SBX_OFF_CTRL);
  wire          start     = ctrl_wr & pwdata[`SBX_CTRL_GO] &
                            (state == ST_IDLE);
  wire          abort     = ctrl_wr & ~pwdata[`SBX_CTRL_GO];
  wire          fin       = eos_fire | (fe_exp & (state == ST_FRAME)) | abort;

  assign codec_side_busy_n      = ~busy;
  assign codec_byte_bus_oe_n    = ~cdir;
  assign codec_sync_strobe_oe_n = ~cdir;
  assign end_of_scan_oe_n       = ~cdir;
  assign stop_oe_n              = cdir;

  sbx_strip_mem #(
    .AW (AW),
    .DW (16)
  ) u_mem (
    .ref_clk (ref_clk),
    .we      (pix_wr_go | cod_wr_go),
    .addr    (phase ? (ctrl_cmp ? {~pix_buf, c_addr} : {pix_buf, f_addr})
                    : (ctrl_cmp ? {pix_buf, pix_addr} : {~pix_buf, c_addr})),
    .wdata   (ctrl_cmp ? wr_word : c_wr_word),
    .rdata   (mem_q)
  );

  // Register bus; zero wait states, so read data is staged in setup
  wire mapped = (paddr == `SBX_OFF_CTRL) | (paddr == `SBX_OFF_X0) |
                (paddr == `SBX_OFF_WIDTH) | (paddr == `SBX_OFF_Y0) |
                (paddr == `SBX_OFF_HEIGHT) | (paddr == `SBX_OFF_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  reg [31:0] rd_val;
  always @*
  begin
    case (paddr)
      `SBX_OFF_CTRL:   rd_val = {28'h0000000, ctrl_tall, ctrl_raster,
                                 ctrl_cmp, ctrl_go};
      `SBX_OFF_X0:     rd_val = {{(32-CW){1'b0}}, win_x0};
      `SBX_OFF_WIDTH:  rd_val = {{(32-CW){1'b0}}, win_w};
      `SBX_OFF_Y0:     rd_val = {{(32-CW){1'b0}}, win_y0};
      `SBX_OFF_HEIGHT: rd_val = {{(32-CW){1'b0}}, win_h};
      `SBX_OFF_STATUS: rd_val = {rows_done[15:0], 8'h00, line_skip, pix_buf,
                                 ~stop_out_n, busy, frame_busy_flag, 1'b0,
                                 state};
      default:         rd_val = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prdata      <= 32'h00000000;
      ctrl_cmp    <= 1'b0;
      ctrl_raster <= 1'b0;
      ctrl_tall   <= 1'b0;
      win_x0      <= `SBX_RST_X0;
      win_w       <= `SBX_RST_WIDTH;
      win_y0      <= `SBX_RST_Y0;
      win_h       <= `SBX_RST_HEIGHT;
    end
    else
    begin
      if (psel & ~penable & ~pwrite)
        prdata <= rd_val;
      if (psel & penable & pwrite)
      begin
        case (paddr)
          `SBX_OFF_CTRL:
          begin
            ctrl_cmp    <= pwdata[`SBX_CTRL_CMP];
            ctrl_raster <= pwdata[`SBX_CTRL_RASTER];
            ctrl_tall   <= pwdata[`SBX_CTRL_TALL];
          end
          `SBX_OFF_X0:     win_x0 <= pwdata[CW-1:0];
          `SBX_OFF_WIDTH:  win_w  <= pwdata[CW-1:0];
          `SBX_OFF_Y0:     win_y0 <= pwdata[CW-1:0];
          `SBX_OFF_HEIGHT: win_h  <= pwdata[CW-1:0];
          default:         ctrl_cmp <= ctrl_cmp;
        endcase
      end
    end
  end

  // Frame sequencing, swap bookkeeping and pixel side
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;       ctrl_go <= 1'b0;     frame_busy_flag <= 1'b0;
      hs_d <= 1'b0;           vs_d <= 1'b0;        ceos_d_n <= 1'b1;
      phase <= 1'b0;          pix_buf <= 1'b0;     pix_done <= 1'b0;
      px <= {CW{1'b0}};       ly <= {CW{1'b0}};    rows_done <= {CW{1'b0}};
      line_on <= 1'b0;        line_skip <= 1'b0;   pix_line <= 5'h00;
      pix_rows <= 5'h00;      pix_final <= 1'b0;   done_pend <= 1'b0;
      pix_addr <= {HA{1'b0}}; wr_lo <= {PW{1'b0}}; wr_word <= 16'h0000;
      wr_pend <= 1'b0;        f_addr <= {HA{1'b0}};
      pixel_output_bus <= {PW{1'b0}};              window_out <= 1'b0;
      stop_out_n <= 1'b1;
    end
    else
    begin
      hs_d <= hs;
      vs_d <= vs;
      ceos_d_n <= ceos_n;
      phase <= ~phase;
      stop_out_n <= ~(ctrl_cmp & ~cdir & ~frame_busy_flag);
      if (hs_rise)
      begin
        px <= {CW{1'b0}};
        ly <= ly_next;
        line_on <= (state == ST_FRAME) & in_y & ~pix_done;
        line_skip <= (state == ST_FRAME) & in_y & pix_done;
      end
      else if (px != {CW{1'b1}})
        px <= px + ONE_C;
      if (vs_rise)
        ly <= {CW{1'b1}};
      // Output follows input except where expanded window data overlays
      pixel_output_bus <= pop | (in_win & ~ctrl_cmp) ?
                          (rel_odd ? qa[15:8] : qa[7:0]) : pix_in;
      window_out <= in_win;
      if (in_win & ctrl_cmp)
      begin
        if (~rel_odd)
          wr_lo <= pix_in;
        else
          wr_word <= {pix_in, wr_lo};
      end
      if (pix_wr_go)
      begin
        pix_addr <= pix_addr + {{(HA-1){1'b0}}, 1'b1};
        wr_pend <= 1'b0;
        if (done_pend)
        begin
          pix_done <= 1'b1;
          done_pend <= 1'b0;
        end
      end
      if (in_win & ctrl_cmp & rel_odd)
        wr_pend <= 1'b1;
      if (rd_p)
        f_addr <= f_addr + {{(HA-1){1'b0}}, 1'b1};
      if (line_last)
      begin
        line_on <= 1'b0;
        rows_done <= rows_done + ONE_C;
        if (strip_end)
        begin
          pix_line <= 5'h00;
          pix_rows <= pix_line + 5'h01;
          pix_final <= row_last;
          if (ctrl_cmp)
            done_pend <= 1'b1;
          else
            pix_done <= 1'b1;
        end
        else
          pix_line <= pix_line + 5'h01;
      end
      if (swap)
      begin
        pix_buf <= ~pix_buf;
        pix_done <= 1'b0;
        pix_addr <= {HA{1'b0}};
        f_addr <= {HA{1'b0}};
        pix_final <= 1'b0;
      end
      case (state)
        ST_IDLE:
          if (start)
          begin
            state <= ST_WAIT;
            ctrl_go <= 1'b1;
            pix_buf <= 1'b0;
            pix_done <= ~pwdata[`SBX_CTRL_CMP];
            rows_done <= {CW{1'b0}};
            pix_line <= 5'h00;
            pix_addr <= {HA{1'b0}};
            f_addr <= {HA{1'b0}};
            done_pend <= 1'b0;
            wr_pend <= 1'b0;
          end
        ST_WAIT:
          if (vs_rise & (ctrl_cmp | ~pix_done))
          begin
            state <= ST_FRAME;
            frame_busy_flag <= frame_busy_flag | ctrl_cmp;
          end
        ST_FRAME:
          if (ctrl_cmp & line_last & row_last)
            state <= ST_DRAIN;
        ST_DRAIN:
          state <= ST_DRAIN;
        default:
          state <= ST_IDLE;
      endcase
      if (active & ~ctrl_cmp & ~csync_n)
        frame_busy_flag <= 1'b1;
      if (fin)
      begin
        state <= ST_IDLE;
        ctrl_go <= 1'b0;
        frame_busy_flag <= 1'b0;
        line_on <= 1'b0;
      end
    end
  end

  // Codec side: block-order address walk, byte serialiser and collector
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      codec_done <= 1'b0;      c_total <= {SWW{1'b0}}; c_cnt <= {SWW{1'b0}};
      c_rows <= 5'h00;         cw <= 2'h0;            cr <= 5'h00;
      row_base <= {HA{1'b0}};  blk_base <= {HA{1'b0}};
      codec_last <= 1'b0;      eos_seen <= 1'b0;      rd_c_d <= 1'b0;
      first_d <= 1'b0;         last_d <= 1'b0;        hi_pend <= 1'b0;
      hi_first <= 1'b0;        last_hold <= 1'b0;     hi_hold <= {PW{1'b0}};
      eos_fire <= 1'b0;        c_lo <= {PW{1'b0}};    c_half <= 1'b0;
      c_wr_word <= 16'h0000;   c_wr_pend <= 1'b0;     rd_p_d <= 1'b0;
      qa <= 16'h0000;          qb <= 16'h0000;        qn <= 2'h0;
      codec_byte_bus_out <= {PW{1'b0}};
      codec_sync_strobe_out_n <= 1'b1;
      end_of_scan_out_n <= 1'b1;
    end
    else
    begin
      rd_c_d <= rd_c;
      first_d <= (cw == 2'h0) & (cr == 5'h00);
      last_d <= codec_last & c_end;
      rd_p_d <= rd_p;
      eos_fire <= hi_pend & last_hold;
      end_of_scan_out_n <= ~eos_fire;
      // One byte per clock: low half on data arrival, high half next
      if (rd_c_d)
      begin
        codec_byte_bus_out <= mem_q[7:0];
        hi_hold <= mem_q[15:8];
        hi_pend <= 1'b1;
        hi_first <= first_d;
        last_hold <= last_d;
        codec_sync_strobe_out_n <= ~(ctrl_raster | first_d);
      end
      else if (hi_pend)
      begin
        codec_byte_bus_out <= hi_hold;
        hi_pend <= 1'b0;
        codec_sync_strobe_out_n <= ~ctrl_raster;
      end
      else
        codec_sync_strobe_out_n <= 1'b1;
      if (cod_wr_go)
        c_wr_pend <= 1'b0;
      if (cbyte_ok)
      begin
        c_half <= ~c_half;
        if (~c_half)
          c_lo <= cbyte_in;
        else
        begin
          c_wr_word <= {cbyte_in, c_lo};
          c_wr_pend <= 1'b1;
        end
      end
      if (c_step)
      begin
        c_cnt <= c_cnt + ONE_S;
        if (c_end)
          codec_done <= 1'b1;
        if (cw == `SBX_BLK_LAST)
        begin
          cw <= 2'h0;
          if (cr == c_rows - 5'h01)
          begin
            cr <= 5'h00;
            row_base <= {HA{1'b0}};
            blk_base <= blk_base + BLK_STEP;
          end
          else
          begin
            cr <= cr + 5'h01;
            row_base <= row_base + half_w[HA-1:0];
          end
        end
        else
          cw <= cw + 2'h1;
      end
      if (ceos_fall & ~ctrl_cmp & active)
      begin
        eos_seen <= 1'b1;
        codec_done <= 1'b1;
      end
      case ({rd_p_d, pop})
        2'b10:
        begin
          if (qn == 2'h0)
            qa <= mem_q;
          else
            qb <= mem_q;
          qn <= qn + 2'h1;
        end
        2'b01:
        begin
          qa <= qb;
          qn <= qn - 2'h1;
        end
        2'b11:
        begin
          qa <= (qn == 2'h1) ? mem_q : qb;
          qb <= mem_q;
        end
        default:
          qn <= qn;
      endcase
      if (swap)
      begin
        cw <= 2'h0;
        cr <= 5'h00;
        row_base <= {HA{1'b0}};
        blk_base <= {HA{1'b0}};
        c_cnt <= {SWW{1'b0}};
        codec_done <= ctrl_cmp ? 1'b0 : eos_seen;
        c_total <= ctrl_cmp ? {{(SWW-HA){1'b0}}, pix_addr} : strip_words;
        c_rows <= ctrl_cmp ? pix_rows : strip_lines;
        codec_last <= ctrl_cmp & pix_final;
      end
      if (start)
      begin
        codec_done <= pwdata[`SBX_CTRL_CMP];
        c_total <= strip_words;
        c_rows <= strip_lines;
        c_cnt <= {SWW{1'b0}};
        cw <= 2'h0;
        cr <= 5'h00;
        row_base <= {HA{1'b0}};
        blk_base <= {HA{1'b0}};
        codec_last <= 1'b0;
        eos_seen <= 1'b0;
        c_half <= 1'b0;
        c_wr_pend <= 1'b0;
        qn <= 2'h0;
        hi_pend <= 1'b0;
      end
    end
  end

endmodule // sbx_strip_exchange

//--- common/sbx_defs.vh
// Register map, field positions and fixed counts of the strip exchange
`ifndef SBX_DEFS_VH
`define SBX_DEFS_VH

`define SBX_OFF_CTRL      8'h00
`define SBX_OFF_X0        8'h04
`define SBX_OFF_WIDTH     8'h08
`define SBX_OFF_Y0        8'h0c
`define SBX_OFF_HEIGHT    8'h10
`define SBX_OFF_STATUS    8'h14

`define SBX_CTRL_GO       0
`define SBX_CTRL_CMP      1
`define SBX_CTRL_RASTER   2
`define SBX_CTRL_TALL     3

`define SBX_RST_X0        17'h00000
`define SBX_RST_WIDTH     17'h00008
`define SBX_RST_Y0        17'h00000
`define SBX_RST_HEIGHT    17'h00008

`define SBX_LINES_BLOCK   5'h08
`define SBX_LINES_TALL    5'h10
`define SBX_LINES_RASTER  5'h01
`define SBX_BLK_WORDS     3'h4
`define SBX_BLK_LAST      2'h3
`define SBX_QDEPTH        2'h2
`define SBX_LOW_PINS      3

`endif

//--- src/sbx_strip_mem.v
// Double strip buffer storage, one 16-bit port, registered read data
`timescale 1ns/10ps
module sbx_strip_mem #(
  parameter AW = 13,
  parameter DW = 16
) (
  input  wire          ref_clk,
  input  wire          we,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Memory array has no reset; contents are don't-care until written
  always @(posedge ref_clk)
  begin
    if (we)
      mem[addr] <= wdata;
    rdata <= mem[addr];
  end

endmodule // sbx_strip_mem

//--- dv/sbx_props.sv
// Port assertions for the strip exchange control
`timescale 1ns/10ps
module sbx_props #(
  parameter PW = 8
) (
  input wire          ref_clk,
  input wire          rst_n,
  input wire [7:0]    paddr,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [31:0]   pwdata,
  input wire          pready,
  input wire          pslverr,
  input wire [PW-1:0] pixel_input_bus,
  input wire [PW-1:0] pixel_output_bus,
  input wire          window_out,
  input wire          codec_side_busy_n,
  input wire          codec_dir_in,
  input wire          codec_sync_strobe_oe_n,
  input wire          end_of_scan_out_n,
  input wire          end_of_scan_oe_n,
  input wire          stop_oe_n,
  input wire          codec_byte_bus_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_go_expand;
    s_access ##0 (pwrite && paddr == 8'h00 && pwdata[1:0] == 2'b01);
  endsequence
  property p_ready; s_access |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_unmapped; s_access ##0 paddr > 8'h14 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  property p_go_busy; s_go_expand |-> ##[1:2] !codec_side_busy_n; endproperty
  a_go_busy: assert property (p_go_busy) else $error("busy late");
  // Two sync stages plus the output register
  property p_pass;
    !window_out |-> pixel_output_bus == $past(pixel_input_bus, 3);
  endproperty
  a_pass: assert property (p_pass) else $error("no pass");
  property p_dir_hi; codec_dir_in [*3] |-> !codec_byte_bus_oe_n; endproperty
  a_dir_hi: assert property (p_dir_hi) else $error("bus not driven");
  property p_dir_lo;
    !codec_dir_in [*3] |-> codec_byte_bus_oe_n && !stop_oe_n;
  endproperty
  a_dir_lo: assert property (p_dir_lo) else $error("bus driven");
  property p_side;
    stop_oe_n != codec_byte_bus_oe_n && end_of_scan_oe_n ==
      codec_byte_bus_oe_n && codec_sync_strobe_oe_n == codec_byte_bus_oe_n;
  endproperty
  a_side: assert property (p_side) else $error("pin sides");
  property p_eos; $fell(end_of_scan_out_n) |=> end_of_scan_out_n; endproperty
  a_eos: assert property (p_eos) else $error("long end pulse");
endmodule // sbx_props

bind sbx_strip_exchange sbx_props #(.PW(PW)) sbx_props_inst (.*);

//--- dv/sbx_codec_model.sv
// Behavioural codec on the far side of the byte bus
`timescale 1ns/10ps
module sbx_codec_model (
  input  wire       ref_clk,
  input  wire       send,
  input  wire [7:0] byte_out,
  input  wire       byte_oe_n,
  input  wire       strobe_out_n,
  output reg        strobe_in_n,
  output reg        eos_in_n,
  output reg  [7:0] byte_in,
  output reg  [7:0] first_byte,
  output reg        got_first
);
  reg [7:0] left;
  initial
  begin
    {strobe_in_n, eos_in_n, got_first} = 3'h6;
    {byte_in, first_byte, left} = 24'h0;
  end
  // One strip of 64 bytes, one a cycle; idle bus toggles
  always @(posedge ref_clk)
  begin
    eos_in_n    <= !(left == 8'h00 && !strobe_in_n);
    strobe_in_n <= left == 8'h00;
    byte_in     <= (left == 8'h00) ? ~byte_in : 8'h40 - left;
    left        <= send ? 8'h40 : (left == 8'h00) ? left : left - 8'h01;
    if (!byte_oe_n && !strobe_out_n && !got_first)
    begin
      first_byte <= byte_out;
      got_first  <= 1'b1;
    end
  end
endmodule // sbx_codec_model

//--- dv/testbench.sv
// Self-checking bench for the strip exchange control
`timescale 1ns/10ps
module testbench;
  reg         ref_clk, rst_n, psel, penable, pwrite, dir, ls, fs, send, err;
  reg         seen_win;
  reg  [7:0]  paddr, pix, wcnt;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire [7:0]  pout, bout, bin, fb;
  wire        pready, pslverr, win, fbusy, cbusy_n, so_n, boe_n, stop_n;
  wire        stop_oe_n, si_n, ei_n, got;
  integer     failures, checks, r, k;
  sbx_strip_exchange sbx_strip_exchange_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pixel_input_bus(pix),
    .line_sync_in(ls), .frame_sync_in(fs), .pixel_output_bus(pout),
    .window_out(win), .frame_busy_flag(fbusy), .codec_side_busy_n(cbusy_n),
    .codec_dir_in(dir), .codec_sync_strobe_in_n(si_n),
    .codec_sync_strobe_out_n(so_n), .codec_sync_strobe_oe_n(),
    .end_of_scan_in_n(ei_n), .end_of_scan_out_n(), .end_of_scan_oe_n(),
    .stop_in_n(1'b1), .stop_out_n(stop_n), .stop_oe_n(stop_oe_n),
    .codec_byte_bus_in(bin), .codec_byte_bus_out(bout),
    .codec_byte_bus_oe_n(boe_n));
  sbx_codec_model sbx_codec_model_inst (
    .ref_clk(ref_clk), .send(send), .byte_out(bout), .byte_oe_n(boe_n),
    .strobe_out_n(so_n), .strobe_in_n(si_n), .eos_in_n(ei_n),
    .byte_in(bin), .first_byte(fb), .got_first(got));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Expanded bytes count up from zero, so window pixel n shows n
  always @(posedge ref_clk)
    if (win === 1'b1 && dir === 1'b0)
    begin
      seen_win <= 1'b1;
      wcnt     <= wcnt + 8'h01;
      chk(pout, wcnt, "expanded");
    end
  task conclude;
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string what);
    checks = checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    for (n = 0; n < 50 && pready !== 1'b1; n = n + 1)
      @(posedge ref_clk);
    chk(pready, 1'b1, "pready");
    if (pready !== 1'b1)
      conclude;
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  function cond(input [1:0] i);
    case (i)
      2'h0: cond = cbusy_n === 1'b1;
      2'h1: cond = fbusy === 1'b1;
      default: cond = fbusy === 1'b0;
    endcase
  endfunction
  task waitc(input [1:0] i, input integer lim);
    integer n;
    for (n = 0; n < lim && !cond(i); n = n + 1)
      @(posedge ref_clk);
    chk(cond(i), 1'b1, "wait");
    if (!cond(i))
      conclude;
  endtask
  task vpulse;
    @(posedge ref_clk);
    fs <= 1'b1;
    repeat (6) @(posedge ref_clk);
    fs <= 1'b0;
  endtask
  // Gap after each line leaves the slack narrow windows need
  task lines(input integer rows);
    for (r = 0; r < rows; r = r + 1)
    begin
      @(posedge ref_clk);
      ls <= 1'b1;
      for (k = 0; k < 8; k = k + 1)
      begin
        @(posedge ref_clk);
        ls  <= 1'b0;
        pix <= 8'(r * 16 + k + 1);
      end
      @(posedge ref_clk);
      pix <= 8'h00;
      repeat (24) @(posedge ref_clk);
    end
  endtask
  task t_regs;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h8, "width");
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h8, "height");
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0, "status");
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1, "slverr");
    chk(rd, 32'h0, "unmapped");
  endtask
  task t_stop;
    apb(1'b1, 8'h00, 32'h2);
    repeat (4) @(posedge ref_clk);
    chk(stop_n, 1'b0, "stop");
    apb(1'b0, 8'h14, 32'h0);
    chk(rd[5], 1'b1, "stop_status");
    apb(1'b1, 8'h00, 32'h0);
  endtask
  task t_comp;
    dir <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(boe_n, 1'b0, "byte_oe");
    chk(stop_oe_n, 1'b1, "stop_oe");
    apb(1'b1, 8'h00, 32'h3);
    vpulse;
    chk(fbusy, 1'b1, "fbusy_rise");
    lines(8);
    waitc(2'h2, 3000);
    chk({got, fb}, 9'h101, "first_byte");
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[0], 1'b0, "go");
  endtask
  task t_exp;
    {dir, seen_win} <= 2'b00;
    repeat (4) @(posedge ref_clk);
    apb(1'b1, 8'h00, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(cbusy_n, 1'b0, "busy");
    lines(2);
    chk(seen_win, 1'b0, "pass");
    send <= 1'b1;
    @(posedge ref_clk);
    send <= 1'b0;
    waitc(2'h1, 20);
    waitc(2'h0, 300);
    vpulse;
    lines(8);
    chk(seen_win, 1'b1, "window");
    waitc(2'h2, 1000);
    chk(wcnt, 8'h40, "window_pixels");
  endtask
  initial
  begin
    {rst_n, psel, penable, pwrite, dir, ls, fs, send, seen_win} = 9'h0;
    {paddr, pix, wcnt, pwdata, rd, err} = 89'h0;
    failures = 0;
    checks = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs;
    t_stop;
    t_comp;
    t_exp;
    conclude;
  end
endmodule // testbench
